/* File: hdl/fcr_defs.svh */
// bit positions, widths and sizes for the feature-control register block
`ifndef FCR_DEFS_SVH
`define FCR_DEFS_SVH
`define FCR_V86_EXT 0
`define FCR_PM_VINT 1
`define FCR_TSC_RESTRICT 2
`define FCR_DEBUG_EXT 3
`define FCR_LARGE_PAGE 4
`define FCR_PAE 5
`define FCR_MC_EXC 6
`define FCR_GLOBAL_PAGE 7
`define FCR_CTR_READ 8
`define FCR_SAVE_RESTORE 9
`define FCR_UNMASKED_SIMD 10
`define FCR_USER_INSTR_PREV 11
`define FCR_SEG_BASE 16
`define FCR_EXT_STATE 18
`define FCR_SUP_EXEC_PREV 20
`define FCR_SUP_ACCESS_PROT 21
`define FCR_WRITABLE_MASK 64'h0000_0000_0035_0fff
`define FCR_RESET_VALUE 64'h0000_0000_0000_0000
`define FCR_TBR_RESET 64'h0000_0000_0000_0000
`define FCR_FAR_RESET 64'h0000_0000_0000_0000
`define FCR_MC_BANKS 4
`define FCR_PHYS_ADDR_EXT_BITS 52
`define FCR_PHYS_ADDR_LEGACY_BITS 32
`define FCR_PAGE_4K 2'h0
`define FCR_PAGE_2M 2'h1
`define FCR_PAGE_4M 2'h2
`define FCR_CR_FEATURE 2'h0
`define FCR_CR_FAULT 2'h1
`define FCR_CR_TBASE 2'h2
`endif

/* File: hdl/fcr_feature_ctrl.sv */
// feature-control register with enable decode and privilege checks
`timescale 1ns/100ps
`default_nettype none
`include "fcr_defs.svh"
module fcr_feature_ctrl (
   input wire logic clk,
   input wire logic rst,
   input wire logic long_mode,
   input wire logic mode_64bit,
   input wire fcr_pkg::fcr_req_s cr_req,
   output logic [63:0] cr_rd_data,
   output logic gp_fault,
   output logic flush_nonglobal,
   input wire logic fault_valid,
   input wire logic [63:0] fault_vaddr,
   output logic [63:0] fault_address_register,
   output logic [63:0] translation_base_register,
   output fcr_pkg::fcr_enables_s enables,
   input wire logic [1:0] cur_priv,
   input wire logic timestamp_read_instr,
   input wire logic perf_counter_read_instr,
   output logic timestamp_read_fault,
   output logic perf_counter_read_fault,
   input wire logic dr_access,
   input wire logic [2:0] dr_index,
   output logic invalid_opcode_exc,
   output logic [2:0] dr_index_eff,
   input wire logic page_size_sel,
   output logic [1:0] page_size,
   output logic [5:0] phys_addr_bits,
   input wire logic global_flag,
   output logic entry_survives_flush,
   input wire logic [`FCR_MC_BANKS-1:0] mc_bank_ctl,
   input wire logic [`FCR_MC_BANKS-1:0] mc_err,
   input wire logic [`FCR_MC_BANKS-1:0] mc_err_uncorrectable,
   input wire logic [`FCR_MC_BANKS-1:0] mc_status_clr,
   output logic [`FCR_MC_BANKS-1:0] mc_bank_status,
   output logic machine_check_exc
);
   fcr_pkg::fcr_st_s st_r;
   fcr_pkg::fcr_st_s st_nxt;
   logic [63:0] f;
   logic [`FCR_MC_BANKS-1:0] mc_rec;

   function automatic logic bitset(input logic [63:0] v, input int pos);
      return v[pos];
   endfunction : bitset

   assign f = st_r.feature;
   assign mc_rec = mc_err & mc_bank_ctl;

   always_comb begin
      st_nxt = st_r;
      st_nxt.gp_fault = 1'b0;
      st_nxt.flush_nonglobal = 1'b0;
      if (fault_valid) begin
         st_nxt.fault_addr = fault_vaddr;
      end
      // set wins over software clear of a status bit
      st_nxt.mc_status = (st_r.mc_status & ~mc_status_clr) | mc_rec;
      case (st_r.state)
         fcr_pkg::FCR_IDLE: begin
            if (cr_req.valid && cr_req.write) begin
               st_nxt.state = fcr_pkg::FCR_WRITE;
               case (cr_req.sel)
                  `FCR_CR_FEATURE: begin
                     if (mode_64bit && (cr_req.data[63:32] != 32'h0000_0000)) begin
                        st_nxt.gp_fault = 1'b1;
                        st_nxt.state = fcr_pkg::FCR_FAULT;
                     end else begin
                        // legacy writes touch only the low half
                        st_nxt.feature = cr_req.data & `FCR_WRITABLE_MASK;
                     end
                  end
                  `FCR_CR_FAULT: st_nxt.fault_addr = cr_req.data;
                  `FCR_CR_TBASE: begin
                     st_nxt.tbase = cr_req.data;
                     st_nxt.flush_nonglobal = 1'b1;
                  end
                  default: st_nxt.state = fcr_pkg::FCR_IDLE;
               endcase
            end else if (cr_req.valid) begin
               case (cr_req.sel)
                  `FCR_CR_FEATURE: st_nxt.rd_data = mode_64bit ? f : {32'h0000_0000, f[31:0]};
                  `FCR_CR_FAULT: st_nxt.rd_data = st_r.fault_addr;
                  `FCR_CR_TBASE: st_nxt.rd_data = st_r.tbase;
                  default: st_nxt.rd_data = 64'h0000_0000_0000_0000;
               endcase
            end
         end
         fcr_pkg::FCR_WRITE: st_nxt.state = fcr_pkg::FCR_IDLE;
         fcr_pkg::FCR_FAULT: st_nxt.state = fcr_pkg::FCR_IDLE;
         default: st_nxt.state = fcr_pkg::FCR_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         st_r <= '{state: fcr_pkg::FCR_IDLE, feature: `FCR_RESET_VALUE,
                   fault_addr: `FCR_FAR_RESET, tbase: `FCR_TBR_RESET,
                   mc_status: '0, rd_data: '0, gp_fault: 1'b0,
                   flush_nonglobal: 1'b0};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign cr_rd_data = st_r.rd_data;
   assign gp_fault = st_r.gp_fault;
   assign flush_nonglobal = st_r.flush_nonglobal;
   assign fault_address_register = st_r.fault_addr;
   assign translation_base_register = st_r.tbase;
   assign mc_bank_status = st_r.mc_status;

   // each enable a level straight from the register, except virt_int_support and large_page_active, which combine two bits
   always_comb begin
      enables.v86_ext_enable = bitset(f, `FCR_V86_EXT);
      enables.pm_virt_int_enable = bitset(f, `FCR_PM_VINT);
      enables.virt_int_support = bitset(f, `FCR_V86_EXT) | bitset(f, `FCR_PM_VINT);
      // protected-mode variant never opens the redirection bitmap
      enables.redirect_bitmap_enable = bitset(f, `FCR_V86_EXT);
      enables.tsc_restrict = bitset(f, `FCR_TSC_RESTRICT);
      enables.io_breakpoint_enable = bitset(f, `FCR_DEBUG_EXT);
      enables.large_page_active = bitset(f, `FCR_LARGE_PAGE) & ~bitset(f, `FCR_PAE);
      enables.phys_addr_ext_enable = bitset(f, `FCR_PAE);
      enables.mc_exc_enable = bitset(f, `FCR_MC_EXC);
      enables.global_page_enable = bitset(f, `FCR_GLOBAL_PAGE);
      enables.counter_read_enable = bitset(f, `FCR_CTR_READ);
      enables.save_restore_support = bitset(f, `FCR_SAVE_RESTORE);
      enables.unmasked_simd_exc_support = bitset(f, `FCR_UNMASKED_SIMD);
      enables.user_instr_prevent = bitset(f, `FCR_USER_INSTR_PREV);
      enables.segment_base_instr_enable = bitset(f, `FCR_SEG_BASE);
      enables.extended_state_enable = bitset(f, `FCR_EXT_STATE);
      enables.supervisor_exec_prevent = bitset(f, `FCR_SUP_EXEC_PREV);
      enables.supervisor_access_protect = bitset(f, `FCR_SUP_ACCESS_PROT);
   end

   assign timestamp_read_fault = timestamp_read_instr && bitset(f, `FCR_TSC_RESTRICT)
                                 && (cur_priv != 2'h0);
   assign perf_counter_read_fault = perf_counter_read_instr && !bitset(f, `FCR_CTR_READ)
                                    && (cur_priv != 2'h0);
   assign invalid_opcode_exc = dr_access && bitset(f, `FCR_DEBUG_EXT)
                               && (dr_index == 3'h4 || dr_index == 3'h5);
   // four and five alias six and seven when extensions are off
   assign dr_index_eff = (!bitset(f, `FCR_DEBUG_EXT) && (dr_index == 3'h4 || dr_index == 3'h5))
                         ? dr_index + 3'h2 : dr_index;

   // long mode implies address extension, so large pages drop out there too
   always_comb begin
      if (bitset(f, `FCR_PAE) || long_mode) begin
         page_size = page_size_sel ? `FCR_PAGE_2M : `FCR_PAGE_4K;
         phys_addr_bits = 6'(`FCR_PHYS_ADDR_EXT_BITS);
      end else begin
         page_size = (bitset(f, `FCR_LARGE_PAGE) && page_size_sel)
                     ? `FCR_PAGE_4M : `FCR_PAGE_4K;
         phys_addr_bits = 6'(`FCR_PHYS_ADDR_LEGACY_BITS);
      end
   end

   assign entry_survives_flush = bitset(f, `FCR_GLOBAL_PAGE) && global_flag;

   assign machine_check_exc = bitset(f, `FCR_MC_EXC)
                              && |(mc_rec & mc_err_uncorrectable);

   a_high_write_gp: assert property (@(posedge clk) disable iff (rst)
      (cr_req.valid && cr_req.write && cr_req.sel == `FCR_CR_FEATURE && mode_64bit
       && st_r.state == fcr_pkg::FCR_IDLE && cr_req.data[63:32] != 32'h0)
      |=> gp_fault && $stable(st_r.feature)) else $error("high bit write without fault");
   a_legacy_read_low: assert property (@(posedge clk) disable iff (rst)
      (cr_req.valid && !cr_req.write && cr_req.sel == `FCR_CR_FEATURE && !mode_64bit
       && st_r.state == fcr_pkg::FCR_IDLE) |=> cr_rd_data[63:32] == 32'h0)
      else $error("legacy read shows high half");
   a_write_takes: assert property (@(posedge clk) disable iff (rst)
      (cr_req.valid && cr_req.write && cr_req.sel == `FCR_CR_FEATURE && !mode_64bit
       && st_r.state == fcr_pkg::FCR_IDLE)
      |=> enables.mc_exc_enable == $past(cr_req.data[`FCR_MC_EXC]))
      else $error("enable not updated next cycle");
   a_tsc_priv: assert property (@(posedge clk) disable iff (rst)
      timestamp_read_fault |-> enables.tsc_restrict && cur_priv != 2'h0)
      else $error("timestamp fault without cause");
   a_pmc_priv: assert property (@(posedge clk) disable iff (rst)
      (perf_counter_read_instr && cur_priv != 2'h0 && !enables.counter_read_enable)
      |-> perf_counter_read_fault) else $error("counter read not blocked");
   a_dr_alias: assert property (@(posedge clk) disable iff (rst)
      (!enables.io_breakpoint_enable && dr_index == 3'h5) |-> dr_index_eff == 3'h7)
      else $error("dr five alias wrong");
   a_dr_reserved: assert property (@(posedge clk) disable iff (rst)
      (enables.io_breakpoint_enable && dr_access && dr_index == 3'h4) |-> invalid_opcode_exc)
      else $error("dr four not reserved");
   a_pae_ignores_pse: assert property (@(posedge clk) disable iff (rst)
      enables.phys_addr_ext_enable |-> page_size != `FCR_PAGE_4M)
      else $error("large page under extension");
   a_mc_gate: assert property (@(posedge clk) disable iff (rst)
      machine_check_exc |-> enables.mc_exc_enable && |(mc_err & mc_err_uncorrectable))
      else $error("machine check raised wrongly");
   a_mc_record: assert property (@(posedge clk) disable iff (rst)
      (mc_err[0] && mc_bank_ctl[0]) |=> mc_bank_status[0])
      else $error("error not recorded");
   a_tbase_flush: assert property (@(posedge clk) disable iff (rst)
      (cr_req.valid && cr_req.write && cr_req.sel == `FCR_CR_TBASE
       && st_r.state == fcr_pkg::FCR_IDLE) |=> flush_nonglobal ##1 !flush_nonglobal)
      else $error("flush pulse missing");
endmodule : fcr_feature_ctrl
`default_nettype wire

/* File: hdl/fcr_pkg.sv */
// types for the feature-control register block
`default_nettype none
package fcr_pkg;
   typedef enum logic [2:0] {
      FCR_IDLE = 3'b001,
      FCR_WRITE = 3'b010,
      FCR_FAULT = 3'b100
   } fcr_state_e;

   // move-to/from control register request from the core
   typedef struct packed {
      logic valid;
      logic write;
      logic [1:0] sel;
      logic [63:0] data;
   } fcr_req_s;

   // consumer-side decoded enables
   typedef struct packed {
      logic v86_ext_enable;
      logic pm_virt_int_enable;
      logic virt_int_support;
      logic redirect_bitmap_enable;
      logic tsc_restrict;
      logic io_breakpoint_enable;
      logic large_page_active;
      logic phys_addr_ext_enable;
      logic mc_exc_enable;
      logic global_page_enable;
      logic counter_read_enable;
      logic save_restore_support;
      logic unmasked_simd_exc_support;
      logic user_instr_prevent;
      logic segment_base_instr_enable;
      logic extended_state_enable;
      logic supervisor_exec_prevent;
      logic supervisor_access_protect;
   } fcr_enables_s;

   typedef struct packed {
      fcr_state_e state;
      logic [63:0] feature;
      logic [63:0] fault_addr;
      logic [63:0] tbase;
      logic [3:0] mc_status;
      logic [63:0] rd_data;
      logic gp_fault;
      logic flush_nonglobal;
   } fcr_st_s;
endpackage : fcr_pkg
`default_nettype wire

/* File: tb/processor_feature_control_reg_tb_top.sv */
// self-checking bench for the feature-control register block
`timescale 1ns/100ps
`default_nettype none
module processor_feature_control_reg_tb_top;
   typedef struct packed {
      logic [63:0] w;
      logic [1:0] pv;
      logic pss;
      logic [2:0] dr;
      logic [63:0] rd;
      logic tsf, pcf, ud;
      logic [2:0] dre;
      logic [1:0] ps;
      logic [5:0] pb;
   } fcr_row_s;
   logic clk, rst, long_mode, mode_64bit, fault_valid, timestamp_read_instr;
   logic perf_counter_read_instr, dr_access, page_size_sel, global_flag;
   logic gp_fault, flush_nonglobal, timestamp_read_fault, perf_counter_read_fault;
   logic invalid_opcode_exc, entry_survives_flush, machine_check_exc, gp_seen, fl_seen;
   logic [63:0] fault_vaddr, cr_rd_data, fault_address_register, translation_base_register, w;
   logic [1:0] cur_priv, page_size;
   logic [2:0] dr_index, dr_index_eff;
   logic [5:0] phys_addr_bits;
   logic [3:0] mc_bank_ctl, mc_err, mc_err_uncorrectable, mc_status_clr, mc_bank_status;
   fcr_pkg::fcr_req_s cr_req;
   fcr_pkg::fcr_enables_s enables;
   int n_tests = 0;
   int err_count = 0;
   fcr_row_s rows [6] = '{
      '{64'h0, 2'h3, 1'h1, 3'h4, 64'h0, 1'h0, 1'h1, 1'h0, 3'h6, 2'h0, 6'h20},
      '{64'h4, 2'h3, 1'h0, 3'h5, 64'h4, 1'h1, 1'h1, 1'h0, 3'h7, 2'h0, 6'h20},
      '{64'h4, 2'h0, 1'h1, 3'h4, 64'h4, 1'h0, 1'h0, 1'h0, 3'h6, 2'h0, 6'h20},
      '{64'h18, 2'h3, 1'h1, 3'h5, 64'h18, 1'h0, 1'h1, 1'h1, 3'h5, 2'h2, 6'h20},
      '{64'h130, 2'h3, 1'h1, 3'h6, 64'h130, 1'h0, 1'h0, 1'h0, 3'h6, 2'h1, 6'h34},
      '{64'hffff_ffff, 2'h2, 1'h1, 3'h5, 64'h35_0fff, 1'h1, 1'h0, 1'h1, 3'h5, 2'h1, 6'h34}};

   fcr_feature_ctrl i_dut (.clk, .rst, .long_mode, .mode_64bit, .cr_req, .cr_rd_data,
      .gp_fault, .flush_nonglobal, .fault_valid, .fault_vaddr, .fault_address_register,
      .translation_base_register, .enables, .cur_priv, .timestamp_read_instr,
      .perf_counter_read_instr, .timestamp_read_fault, .perf_counter_read_fault,
      .dr_access, .dr_index, .invalid_opcode_exc, .dr_index_eff, .page_size_sel,
      .page_size, .phys_addr_bits, .global_flag, .entry_survives_flush, .mc_bank_ctl,
      .mc_err, .mc_err_uncorrectable, .mc_status_clr, .mc_bank_status, .machine_check_exc);

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      n_tests++;
      if (got !== exp) begin
         err_count++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic complete_run();
      $display("checks=%0d mismatches=%0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : complete_run

   // write holds valid through the taking edge, then spends the busy cycle
   task automatic wr(input logic [1:0] sel, input logic [63:0] d);
      cr_req = '{1'b1, 1'b1, sel, d};
      @(posedge clk);
      #1 cr_req.valid = 1'b0;
      gp_seen = gp_fault;
      fl_seen = flush_nonglobal;
      @(posedge clk);
      #1;
   endtask : wr

   // idle edge at the end, so the next request never lands in the release step
   task automatic rd(input logic [1:0] sel, input logic [63:0] exp);
      cr_req = '{1'b1, 1'b0, sel, 64'h0};
      @(posedge clk);
      #1 cr_req.valid = 1'b0;
      chk(cr_rd_data, exp);
      @(posedge clk);
      #1;
   endtask : rd

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   initial begin
      repeat (2000) @(posedge clk);
      err_count++;
      complete_run();
   end

   initial begin
      {rst, long_mode, mode_64bit, fault_valid, timestamp_read_instr} = 5'h15;
      {perf_counter_read_instr, dr_access, page_size_sel, global_flag} = 4'hd;
      {mc_bank_ctl, mc_err, mc_err_uncorrectable, mc_status_clr, cur_priv, dr_index} = '0;
      cr_req = '0;
      fault_vaddr = '0;
      repeat (5) @(posedge clk);
      #1 rst = 1'b0;
      rd(2'h0, 64'h0);
      foreach (rows[i]) begin
         cur_priv = rows[i].pv;
         page_size_sel = rows[i].pss;
         dr_index = rows[i].dr;
         wr(2'h0, rows[i].w);
         rd(2'h0, rows[i].rd);
         w = rows[i].rd;
         chk(enables, {w[0], w[1], w[0] | w[1], w[0], w[2], w[3], w[4] & ~w[5], w[5], w[6], w[7],
            w[8], w[9], w[10], w[11], w[16], w[18], w[20], w[21]});
         chk(timestamp_read_fault, rows[i].tsf);
         chk(perf_counter_read_fault, rows[i].pcf);
         chk(invalid_opcode_exc, rows[i].ud);
         if (!rows[i].ud) chk(dr_index_eff, rows[i].dre);
         chk(page_size, rows[i].ps);
         chk(phys_addr_bits, rows[i].pb);
         chk(entry_survives_flush, w[7]);
      end
      mode_64bit = 1'b0;
      wr(2'h0, 64'hffff_0000_0000_0010);
      chk(gp_seen, 1'b0);
      rd(2'h0, 64'h10);
      mode_64bit = 1'b1;
      wr(2'h0, 64'h1_0000_0040);
      chk(gp_seen, 1'b1);
      rd(2'h0, 64'h10);
      // extension switched on before long mode; large pages must drop out
      wr(2'h0, 64'h30);
      long_mode = 1'b1;
      #1 chk(page_size, 2'h1);
      chk(phys_addr_bits, 6'h34);
      long_mode = 1'b0;
      // second request lands in the busy cycle and must vanish
      cr_req = '{1'b1, 1'b1, 2'h0, 64'h80};
      @(posedge clk);
      #1 cr_req.data = 64'h40;
      @(posedge clk);
      #1;
      rd(2'h0, 64'h80);
      wr(2'h2, 64'h1234_5000);
      chk(fl_seen, 1'b1);
      rd(2'h2, 64'h1234_5000);
      chk(translation_base_register, 64'h1234_5000);
      chk(entry_survives_flush, 1'b1);
      global_flag = 1'b0;
      #1 chk(entry_survives_flush, 1'b0);
      fault_valid = 1'b1;
      fault_vaddr = 64'hdead_beef_0000_1000;
      @(posedge clk);
      #1 fault_valid = 1'b0;
      rd(2'h1, 64'hdead_beef_0000_1000);
      chk(fault_address_register, 64'hdead_beef_0000_1000);
      wr(2'h3, 64'hffff);
      rd(2'h3, 64'h0);
      mc_bank_ctl = 4'h3;
      mc_err = 4'h3;
      mc_err_uncorrectable = 4'h2;
      #1 chk(machine_check_exc, 1'b0);
      @(posedge clk);
      #1 mc_err = 4'h0;
      chk(mc_bank_status, 4'h3);
      wr(2'h0, 64'h40);
      mc_err = 4'h6;
      mc_err_uncorrectable = 4'h6;
      #1 chk(machine_check_exc, 1'b1);
      @(posedge clk);
      #1 mc_err = 4'h0;
      chk(mc_bank_status, 4'h3);
      mc_status_clr = 4'h3;
      @(posedge clk);
      #1 mc_status_clr = 4'h0;
      chk(mc_bank_status, 4'h0);
      mc_err = 4'h1;
      mc_err_uncorrectable = 4'h0;
      #1 chk(machine_check_exc, 1'b0);
      @(posedge clk);
      #1 mc_err = 4'h0;
      chk(mc_bank_status, 4'h1);
      rst = 1'b1;
      @(posedge clk);
      #1 rst = 1'b0;
      rd(2'h0, 64'h0);
      chk(mc_bank_status, 4'h0);
      complete_run();
   end
endmodule : processor_feature_control_reg_tb_top
`default_nettype wire
